// ### rtl/pwm_forced_output_stop.sv
// forced output stop control for a two-output pwm timer, avalon-mm slave
// assumes: comparators, interrupt input and counter period pulse are on clk_sys
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns
`include "fos_consts.svh"

module pwm_forced_output_stop
  import fos_pkg::*;
#(
  parameter int ADDR_W = 22
)
(
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic [ADDR_W-1:0]  address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  input  wire logic [3:0]         byteenable,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  input  wire logic               comparator_zero,
  input  wire logic               comparator_one,
  input  wire logic               comparator_two,
  input  wire logic               external_irq_input,
  input  wire logic               timer_count_enable,
  input  wire logic               counter_period,
  input  wire logic [1:0]         pwm_in,
  output logic [1:0]              pwm_out,
  output logic [1:0]              pwm_oe
);

  // -----------------------------------------------------------------
  // parameter check
  // -----------------------------------------------------------------
  if (ADDR_W < `FOS_ADDR_MIN) begin : g_bad_addr
    $error("address too narrow for the register map");
  end

  typedef struct packed {
    ctl_type [1:0] ctl;
    logic          waitrequest;
    logic [31:0]   readdata;
    logic [1:0]    pwm_out;
    logic [1:0]    pwm_oe;
  } top_state_type;

  top_state_type         st;
  top_state_type         next_st;
  trig_in_type           trig;
  stop_state_type [1:0]  stop;
  logic [1:0]            release_wr;
  logic [`FOS_IDX_W-1:0] idx;
  logic                  wr_fire;
  logic                  rd_take;

  // word index of a byte address
  function automatic logic [`FOS_IDX_W-1:0] word_index(input logic [ADDR_W-1:0] a);
    return `FOS_IDX_W'(a >> 2);
  endfunction

  // lane-merged write of a 16-bit control word, reserved bits kept zero
  function automatic ctl_type ctl_merge(input ctl_type old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = d[7:0];
    end
    if (be[1]) begin
      v[15:8] = d[15:8];
    end
    return ctl_type'(v & `FOS_CTL_WMASK);
  endfunction

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  always_comb begin
    idx = word_index(address);
    // a write lands at the edge where waitrequest is seen low
    wr_fire = write & ~st.waitrequest;
    rd_take = read & st.waitrequest;
    trig.irq = external_irq_input;
    trig.cmp = {comparator_two, comparator_one, comparator_zero};
    release_wr = 2'b00;
    if (wr_fire && idx == `FOS_IDX_RELEASE && byteenable[0]) begin
      release_wr = writedata[1:0];
    end
  end

  // -----------------------------------------------------------------
  // stop channels, one per control register
  // -----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_chan
    stop_channel u_chan (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .ctl        (st.ctl[p]),
      .trig       (trig),
      .period     (counter_period),
      .count_en   (timer_count_enable),
      .release_wr (release_wr[p]),
      .stop       (stop[p])
    );
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // one wait state: answer on the cycle after the request appears
    next_st.waitrequest = ~((read | write) & st.waitrequest);
    if (rd_take) begin
      unique case (idx)
        `FOS_IDX_CTL0: begin
          next_st.readdata = {16'h0000, st.ctl[0]};
        end
        `FOS_IDX_CTL1: begin
          next_st.readdata = {16'h0000, st.ctl[1]};
        end
        `FOS_IDX_STATUS: begin
          next_st.readdata = {28'h000_0000, stop[1], stop[0]};
        end
        default: begin
          next_st.readdata = 32'h0000_0000;
        end
      endcase
    end
    if (wr_fire) begin
      if (idx == `FOS_IDX_CTL0) begin
        next_st.ctl[0] = ctl_merge(st.ctl[0], writedata, byteenable);
      end
      if (idx == `FOS_IDX_CTL1) begin
        next_st.ctl[1] = ctl_merge(st.ctl[1], writedata, byteenable);
      end
    end
    // output forcing; stop 1 outranks stop 2 when both are active
    for (int p = 0; p < 2; p++) begin
      if (stop[p].stop1) begin
        next_st.pwm_oe[p]  = st.ctl[p].lvl[1];
        next_st.pwm_out[p] = st.ctl[p].lvl[0] & st.ctl[p].lvl[1];
      end else if (stop[p].stop2) begin
        next_st.pwm_oe[p]  = 1'b1;
        next_st.pwm_out[p] = st.ctl[p].lvl[0];
      end else begin
        next_st.pwm_oe[p]  = 1'b1;
        next_st.pwm_out[p] = pwm_in[p];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st.ctl         <= {`FOS_CTL_RESET, `FOS_CTL_RESET};
      st.waitrequest <= 1'b1;
      st.readdata    <= 32'h0000_0000;
      st.pwm_out     <= 2'b00;
      st.pwm_oe      <= 2'b00;
    end else begin
      st <= next_st;
    end
  end

  assign readdata    = st.readdata;
  assign waitrequest = st.waitrequest;
  assign pwm_out     = st.pwm_out;
  assign pwm_oe      = st.pwm_oe;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_level_hiz: assert property (
    stop[0].stop1 && st.ctl[0].lvl[1] == 1'b0 |=> !pwm_oe[0])
    else $error("stop 1 did not float output 0");
  chk_level_stop2: assert property (
    stop[1].stop2 && !stop[1].stop1 |=> pwm_oe[1] && pwm_out[1] == $past(st.ctl[1].lvl[0]))
    else $error("stop 2 forced wrong level on output 1");
  chk_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one wait state");
  chk_ctl_write: assert property (
    write && !waitrequest && idx == `FOS_IDX_CTL0 && byteenable == 4'hf
      |=> st.ctl[0] == ($past(writedata[15:0]) & `FOS_CTL_WMASK))
    else $error("control write not stored");

  cov_ctl_read: cover property (read && !waitrequest && idx == `FOS_IDX_CTL1);
  cov_forced_high: cover property (pwm_oe[0] && pwm_out[0] && stop[0].stop1);
  cov_release: cover property (release_wr[0] && stop[0].stop1);

endmodule

// ### rtl/fos_consts.svh
// constants of the forced output stop block: word indexes, masks, field positions
// assumes: included by bare name into files that use the package fos_pkg
//
// Notes on behaviour
// - bit 15 lets the external interrupt input start stop function 2
// - bits 14..12 enable comparators 2..0 as stop function 2 sources
// - bits 6..4 enable comparators 2..0 as stop function 1 sources
// - mode bit 8 clear: function 2 releases at the next counter period
// - mode bit 8 set: release at first period after trigger's reverse edge
// - clear field 00: release write clears function 1 at once
// - clear field 01: release write ignored while trigger active, else immediate
// - clear field 10: release write clears function 1 at next period
// - clear field 11: ignored while trigger active, else clears at next period
// - output field picks forced levels for function 1 and function 2
// - count enable low holds stop 2 and a deferred stop 1 (clear field 1x) until counting resumes
// - two control registers, reset 0000, readable and writable
`ifndef FOS_CONSTS_SVH
`define FOS_CONSTS_SVH

// -----------------------------------------------------------------
// register word indexes (byte address is four times the index)
// -----------------------------------------------------------------
`define FOS_IDX_CTL0    20'hf_0630
`define FOS_IDX_CTL1    20'hf_0632
`define FOS_IDX_RELEASE 20'hf_0634
`define FOS_IDX_STATUS  20'hf_0636
`define FOS_IDX_W       20

// -----------------------------------------------------------------
// values and masks
// -----------------------------------------------------------------
`define FOS_CTL_RESET   16'h0000
`define FOS_CTL_WMASK   16'hf17f
`define FOS_ADDR_MIN    22
`define FOS_CLR_NONE    2'b00
`define FOS_CLR_GATED   2'b01

`endif

// ### rtl/fos_pkg.sv
// types shared by the forced output stop block
// assumes: nothing beyond a SystemVerilog compiler
package fos_pkg;

  // one control register, msb first
  typedef struct packed {
    logic       irq_en;
    logic [2:0] src2;
    logic [2:0] rsv_hi;
    logic       mode2;
    logic       rsv_lo;
    logic [2:0] src1;
    logic [1:0] clr1;
    logic [1:0] lvl;
  } ctl_type;

  // trigger inputs seen by one channel
  typedef struct packed {
    logic       irq;
    logic [2:0] cmp;
  } trig_in_type;

  typedef struct packed {
    logic stop1;
    logic stop2;
  } stop_state_type;

endpackage

// ### rtl/stop_channel.sv
// one forced output stop channel: trigger select, engage and release
// assumes: all inputs synchronous to clk_sys, period is a one-cycle pulse
`timescale 1ns/1ns
`include "fos_consts.svh"

module stop_channel
  import fos_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           sys_rst,
  input  wire ctl_type        ctl,
  input  wire trig_in_type    trig,
  input  wire logic           period,
  input  wire logic           count_en,
  input  wire logic           release_wr,
  output stop_state_type      stop
);

  typedef struct packed {
    logic stop1;
    logic stop2;
    logic trig1_d;
    logic trig2_d;
    logic rev_seen;
    logic rel_pend;
  } chan_state_type;

  chan_state_type st;
  chan_state_type next_st;
  logic           trig1;
  logic           trig2;
  logic           rise1;
  logic           rise2;
  logic           period_ok;
  logic           accept;
  logic           clear1;
  logic           clear2;

  // -----------------------------------------------------------------
  // trigger select and edges
  // -----------------------------------------------------------------
  always_comb begin
    trig1 = |(ctl.src1 & trig.cmp);
    trig2 = (|(ctl.src2 & trig.cmp)) | (ctl.irq_en & trig.irq);
    rise1 = trig1 & ~st.trig1_d;
    rise2 = trig2 & ~st.trig2_d;
    // a stopped counter gives no period, so a release at a period waits for restart
    period_ok = period & count_en;
    accept = release_wr & st.stop1 & ~(ctl.clr1[0] & trig1);
    clear1 = ctl.clr1[1] ? (st.rel_pend & period_ok)
                         : accept;
    clear2 = period_ok & (~ctl.mode2 | st.rev_seen);
  end

  // -----------------------------------------------------------------
  // next state; an engage in the release cycle wins
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.trig1_d = trig1;
    next_st.trig2_d = trig2;
    next_st.stop1 = rise1 | (st.stop1 & ~clear1);
    next_st.stop2 = rise2 | (st.stop2 & ~clear2);
    if (rise1 | clear1) begin
      next_st.rel_pend = 1'b0;
    end else if (accept & ctl.clr1[1]) begin
      next_st.rel_pend = 1'b1;
    end
    if (rise2 | clear2) begin
      next_st.rev_seen = 1'b0;
    end else if (st.stop2 & st.trig2_d & ~trig2) begin
      next_st.rev_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stop.stop1 = st.stop1;
  assign stop.stop2 = st.stop2;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_irq_ignored: assert property (
    $rose(trig.irq) && !ctl.irq_en && ctl.src2 == 3'b000 && !st.stop2 |=> !st.stop2)
    else $error("masked interrupt input started stop 2");
  chk_src2_engage: assert property (
    !st.trig2_d && |(ctl.src2 & trig.cmp) |=> st.stop2)
    else $error("enabled comparator did not start stop 2");
  chk_src1_engage: assert property (
    !st.trig1_d && |(ctl.src1 & trig.cmp) |=> st.stop1)
    else $error("enabled comparator did not start stop 1");
  chk_mode0_release: assert property (
    st.stop2 && !ctl.mode2 && period && count_en && !rise2 |=> !st.stop2)
    else $error("stop 2 not released at period");
  chk_mode1_hold: assert property (
    st.stop2 && ctl.mode2 && !st.rev_seen |=> st.stop2)
    else $error("stop 2 released before reverse edge");
  chk_imm_release: assert property (
    st.stop1 && ctl.clr1 == `FOS_CLR_NONE && release_wr && !rise1 |=> !st.stop1)
    else $error("release write did not clear stop 1");
  chk_gated_ignore: assert property (
    st.stop1 && ctl.clr1 == `FOS_CLR_GATED && release_wr && trig1 |=> st.stop1)
    else $error("release honoured while trigger active");
  chk_deferred_hold: assert property (
    st.stop1 && ctl.clr1[1] && !period_ok |=> st.stop1)
    else $error("deferred release left before period");
  chk_halt_hold: assert property (
    st.stop2 && !count_en |=> st.stop2)
    else $error("stop 2 dropped while counter halted");

  cov_stop2_cycle: cover property (st.stop2 ##[1:20] !st.stop2);
  cov_stop1_gated: cover property (st.stop1 && ctl.clr1 == 2'b11 ##[1:20] !st.stop1);

endmodule

// ### tb/far_side.sv
// far side model: comparators, interrupt input, counter and pwm source
// assumes: bench sets the requested levels right after a rising edge
`timescale 1ns/1ns

module far_side (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [2:0] cmp_req,
  input  wire logic       irq_req,
  input  wire logic       run,
  input  wire logic [1:0] trig_en,
  output logic            comparator_zero,
  output logic            comparator_one,
  output logic            comparator_two,
  output logic            external_irq_input,
  output logic            timer_count_enable,
  output logic            counter_period,
  output logic [1:0]      pwm_in
);
  logic [2:0] cnt;

  // comparators 0 and 2 reach the timer only once enabled
  assign comparator_zero    = cmp_req[0] & trig_en[0];
  assign comparator_one     = cmp_req[1];
  assign comparator_two     = cmp_req[2] & trig_en[1];
  assign external_irq_input = irq_req;
  assign timer_count_enable = run;
  assign pwm_in             = 2'b10;

  // a stopped counter makes no period pulse
  always_ff @(posedge clk_sys) begin
    if (sys_rst | ~run) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
  assign counter_period = run & (cnt == 3'h7);
endmodule

// ### tb/pwm_forced_output_stop_test.sv
// bench for the forced output stop block, avalon master and far side model
// assumes: design of rtl/, far_side model, one 50 MHz clock
`timescale 1ns/1ns
`include "fos_consts.svh"

module pwm_forced_output_stop_test
  import fos_pkg::*;
;
  logic        clk_sys    = 1'b0;
  logic        sys_rst    = 1'b1;
  logic [21:0] address    = 22'h00_0000;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [31:0] writedata  = 32'h0000_0000;
  logic [3:0]  byteenable = 4'h0;
  logic [2:0]  cmp_req    = 3'h0;
  logic        irq_req    = 1'b0;
  logic        run        = 1'b0;
  logic [1:0]  trig_en    = 2'b11;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        cz, co, ct, irq, cen, per;
  logic [1:0]  pwm_in, pwm_out, pwm_oe;
  int          errors     = 0;
  int          n_checks   = 0;

  always #10 clk_sys = ~clk_sys;

  pwm_forced_output_stop pwm_forced_output_stop_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .comparator_zero(cz), .comparator_one(co),
    .comparator_two(ct), .external_irq_input(irq), .timer_count_enable(cen), .counter_period(per),
    .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  far_side far_side_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmp_req(cmp_req), .irq_req(irq_req),
    .run(run), .trig_en(trig_en), .comparator_zero(cz), .comparator_one(co), .comparator_two(ct),
    .external_irq_input(irq), .timer_count_enable(cen), .counter_period(per), .pwm_in(pwm_in));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // waits on waitrequest itself; latency is judged afterwards, never assumed
  task automatic bus(input logic wr, input logic [19:0] idx, input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0000, d};
    byteenable <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0);
    q = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
    chk("wait states", 16'(n), 16'h0002);
  endtask

  task automatic wr(input logic [19:0] idx, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [19:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, q);
    chk(what, q, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic trig(input logic [2:0] c, input logic i);
    @(posedge clk_sys);
    cmp_req <= c;
    irq_req <= i;
  endtask

  // a missing period is caught by the watchdog
  task automatic wait_period;
    do begin
      @(posedge clk_sys);
    end while (per !== 1'b1);
    @(posedge clk_sys);
  endtask

  // channel 1 is never stopped here, so it shows pwm_in[1] driven
  task automatic pins(input logic oe0, input logic o0);
    chk("pins", {12'h000, pwm_oe, pwm_out}, {12'h000, 1'b1, oe0, 1'b1, o0});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd_chk("ctl0 reset", `FOS_IDX_CTL0, 16'h0000);
    rd_chk("ctl1 reset", `FOS_IDX_CTL1, 16'h0000);
    pins(1'b1, 1'b0);
    wr(`FOS_IDX_CTL1, 16'hf17f);
    rd_chk("ctl1 rw", `FOS_IDX_CTL1, 16'hf17f);
    rd_chk("ctl0 kept", `FOS_IDX_CTL0, 16'h0000);
    wr(`FOS_IDX_CTL1, 16'h0000);
    rd_chk("unmapped", 20'hf_0638, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_src;
    ctl_type c;
    for (int k = 0; k < 3; k++) begin
      c = '0;
      c.src1 = 3'h1 << k;
      c.lvl = 2'b11;
      wr(`FOS_IDX_CTL0, 16'(c));
      trig(~c.src1, 1'b1);
      tick(3);
      pins(1'b1, 1'b0);
      trig(3'h7, 1'b1);
      tick(3);
      pins(1'b1, 1'b1);
      wr(`FOS_IDX_RELEASE, 16'h0001);
      rd_chk("f1 released", `FOS_IDX_STATUS, 16'h0000);
      trig(3'h0, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.lvl = 2'b01;
      if (k == 3) c.irq_en = 1'b1;
      else c.src2 = 3'h1 << k;
      wr(`FOS_IDX_CTL0, 16'(c));
      trig((k == 3) ? 3'h7 : ~c.src2, 1'(k != 3));
      tick(3);
      pins(1'b1, 1'b0);
      trig(3'h7, 1'b1);
      tick(3);
      pins(1'b1, 1'b1);
      trig(3'h0, 1'b0);
      run <= 1'b1;
      wait_period;
      run <= 1'b0;
      rd_chk("f2 period", `FOS_IDX_STATUS, 16'h0000);
    end
    $display("test sources done");
  endtask

  task automatic t_mode2;
    ctl_type c;
    c = '0;
    c.src2 = 3'h1;
    c.mode2 = 1'b1;
    c.lvl = 2'b01;
    wr(`FOS_IDX_CTL0, 16'(c));
    trig(3'h1, 1'b0);
    run <= 1'b1;
    wait_period;
    rd_chk("f2 held", `FOS_IDX_STATUS, 16'h0001);
    pins(1'b1, 1'b1);
    trig(3'h0, 1'b0);
    wait_period;
    run <= 1'b0;
    rd_chk("f2 edge", `FOS_IDX_STATUS, 16'h0000);
    $display("test mode2 done");
  endtask

  task automatic t_clr01;
    wr(`FOS_IDX_CTL0, 16'h0027);
    trig(3'h2, 1'b0);
    wr(`FOS_IDX_RELEASE, 16'h0001);
    rd_chk("01 active", `FOS_IDX_STATUS, 16'h0002);
    trig(3'h0, 1'b0);
    wr(`FOS_IDX_RELEASE, 16'h0001);
    rd_chk("01 idle", `FOS_IDX_STATUS, 16'h0000);
    $display("test clear01 done");
  endtask

  task automatic t_clr10;
    wr(`FOS_IDX_CTL0, 16'h002b);
    trig(3'h2, 1'b0);
    wr(`FOS_IDX_RELEASE, 16'h0001);
    tick(20);
    rd_chk("10 waits", `FOS_IDX_STATUS, 16'h0002);
    run <= 1'b1;
    wait_period;
    run <= 1'b0;
    rd_chk("10 period", `FOS_IDX_STATUS, 16'h0000);
    trig(3'h0, 1'b0);
    $display("test clear10 done");
  endtask

  task automatic t_clr11;
    wr(`FOS_IDX_CTL0, 16'h002f);
    trig(3'h2, 1'b0);
    wr(`FOS_IDX_RELEASE, 16'h0001);
    run <= 1'b1;
    wait_period;
    run <= 1'b0;
    rd_chk("11 active", `FOS_IDX_STATUS, 16'h0002);
    trig(3'h0, 1'b0);
    wr(`FOS_IDX_RELEASE, 16'h0001);
    rd_chk("11 defer", `FOS_IDX_STATUS, 16'h0002);
    run <= 1'b1;
    wait_period;
    run <= 1'b0;
    rd_chk("11 period", `FOS_IDX_STATUS, 16'h0000);
    $display("test clear11 done");
  endtask

  task automatic t_lvl;
    ctl_type c;
    for (int l = 0; l < 4; l++) begin
      c = '0;
      c.src1 = 3'h2;
      c.src2 = 3'h4;
      c.lvl = 2'(l);
      wr(`FOS_IDX_CTL0, 16'(c));
      trig(3'h2, 1'b0);
      tick(3);
      pins(c.lvl[1], c.lvl[1] & c.lvl[0]);
      rd_chk("lvl f1 on", `FOS_IDX_STATUS, 16'h0002);
      wr(`FOS_IDX_RELEASE, 16'h0001);
      trig(3'h4, 1'b0);
      tick(3);
      pins(1'b1, c.lvl[0]);
      rd_chk("lvl f2 on", `FOS_IDX_STATUS, 16'h0001);
      trig(3'h0, 1'b0);
      run <= 1'b1;
      wait_period;
      run <= 1'b0;
    end
    $display("test levels done");
  endtask

  // channel 1: both functions from comparator 0, stop 1 and stop 2 force the same pin levels here
  task automatic t_chan1;
    wr(`FOS_IDX_CTL1, 16'h1012);
    trig(3'h1, 1'b0);
    tick(3);
    chk("ch1 pins f1", {12'h000, pwm_oe, pwm_out}, 16'h000c);
    rd_chk("ch1 both on", `FOS_IDX_STATUS, 16'h000c);
    wr(`FOS_IDX_RELEASE, 16'h0002);
    rd_chk("ch1 f1 off", `FOS_IDX_STATUS, 16'h0004);
    chk("ch1 pins f2", {12'h000, pwm_oe, pwm_out}, 16'h000c);
    trig(3'h0, 1'b0);
    run <= 1'b1;
    wait_period;
    run <= 1'b0;
    rd_chk("ch1 f2 off", `FOS_IDX_STATUS, 16'h0000);
    wr(`FOS_IDX_CTL1, 16'h0000);
    $display("test channel1 done");
  endtask

  // ----------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_src;
    t_mode2;
    t_clr01;
    t_clr10;
    t_clr11;
    t_lvl;
    t_chan1;
    close_out;
  end

  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    close_out;
  end
endmodule
